// ---- verilog/amip_consts.vh ----
// constants for the macroblock inline command host
// Summary of operation
// - one chroma code holds for every macroblock command of a picture.
// - adaptive frame bit 0 progressive, 1 adaptive; forced zero for field pictures.
// - luma coded pattern in third dword bits 13:8 may stay unprogrammed.
// - row position is an unsigned 8-bit macroblock count, field pair uses field origin.
// - column position is an unsigned 8-bit macroblock count in the low byte.
// - field indicator is 00 or 11, from adaptive frame AND field macroblock.
// - parity bit: pair second for field macroblocks in adaptive, bottom in field, zero in progressive.
// - motion vector code is written zero for intra macroblocks.
// - intra bit: 0 P or B, 1 I; switching intra is never submitted.
// - P macroblock weighting keeps upper bit zero, lower bit holds single flag.
// - both weighting fields are written zero for intra macroblocks.
`ifndef AMIP_CONSTS_VH
`define AMIP_CONSTS_VH

// register byte addresses
`define AMIP_ADDR_PIC      8'h00
`define AMIP_ADDR_POS      8'h04
`define AMIP_ADDR_MB       8'h08
`define AMIP_ADDR_CTRL     8'h0C
`define AMIP_ADDR_STAT     8'h10
`define AMIP_ADDR_ACTIVE   8'h14
`define AMIP_ADDR_DW0      8'h18
`define AMIP_ADDR_DW1      8'h1C
`define AMIP_ADDR_DW2      8'h20

// reset values
`define AMIP_PIC_RST       8'h00
`define AMIP_POS_RST       16'h0000
`define AMIP_MB_RST        30'h0000000
`define AMIP_ERR_RST       4'h0
`define AMIP_CNT_RST       8'h00

// picture register fields
`define AMIP_PIC_CHROMA    1:0
`define AMIP_PIC_FIELD     2
`define AMIP_PIC_ADAPT     3
`define AMIP_PIC_BOTTOM    4
`define AMIP_PIC_BIMODE    6:5
`define AMIP_PIC_SINGLE    7

// macroblock register fields
`define AMIP_MB_CBP        5:0
`define AMIP_MB_MV         8:6
`define AMIP_MB_XFORM      9
`define AMIP_MB_FIELD      10
`define AMIP_MB_INTRA      11
`define AMIP_MB_KIND       16:12
`define AMIP_MB_BIDIR      17
`define AMIP_MB_SECOND     18
`define AMIP_MB_DCY        19
`define AMIP_MB_DCB        20
`define AMIP_MB_DCR        21
`define AMIP_MB_CBPB       25:22
`define AMIP_MB_CBPR       29:26

// control register bits
`define AMIP_CTRL_GO       0
`define AMIP_CTRL_PIC      1
`define AMIP_CTRL_CLR      2

// encodings
`define AMIP_CHROMA_MONO   2'h0
`define AMIP_CHROMA_420    2'h1
`define AMIP_BIMODE_RSVD   2'h3
`define AMIP_MV_NONE       3'h0
`define AMIP_MV_ONE_PAIR   3'h2
`define AMIP_MV_FOUR_PAIR  3'h4
`define AMIP_MV_SIXTEEN    3'h5
`define AMIP_MV_SIXTEEN_PR 3'h6
`define AMIP_LAST_INDEX    2'h2

`endif

// ---- verilog/amip_pack.v ----
// latches one macroblock's fields and packs them into three inline dwords
`timescale 1ns/1ps
`include "amip_consts.vh"
module amip_pack (
	input  wire        i_core_clk,
	input  wire        i_rst_n,
	input  wire        i_capture,
	input  wire [1:0]  i_chroma_sampling_code,
	input  wire        i_picture_is_field_bit,
	input  wire        i_adaptive_frame_picture_bit,
	input  wire        i_bottom_field_bit,
	input  wire [1:0]  i_bidir_weighting_mode,
	input  wire        i_single_weighting_bit,
	input  wire [7:0]  i_mb_column_position,
	input  wire [7:0]  i_mb_row_position,
	input  wire [29:0] i_mb_cfg,
	output reg  [31:0] o_dw0,
	output reg  [31:0] o_dw1,
	output reg  [31:0] o_dw2
);

	reg        intra;
	reg        field_mb;
	reg        adaptive;
	reg        parity;
	reg [2:0]  mv_code;
	reg [1:0]  bimode;
	reg        single;
	reg [31:0] dw0_next;
	reg [31:0] dw1_next;
	reg [31:0] dw2_next;

	// compose the dwords; every reserved position is driven zero
	always @* begin
		intra    = i_mb_cfg[`AMIP_MB_INTRA];
		field_mb = i_mb_cfg[`AMIP_MB_FIELD];
		adaptive = i_adaptive_frame_picture_bit & ~i_picture_is_field_bit;
		if (adaptive)
			parity = field_mb & i_mb_cfg[`AMIP_MB_SECOND];
		else if (i_picture_is_field_bit)
			parity = i_bottom_field_bit;
		else
			parity = 1'b0;
		mv_code = intra ? `AMIP_MV_NONE : i_mb_cfg[`AMIP_MB_MV];
		if (intra) begin
			bimode = 2'h0;
			single = 1'b0;
		end else if (i_mb_cfg[`AMIP_MB_BIDIR]) begin
			bimode = i_bidir_weighting_mode;
			single = i_single_weighting_bit;
		end else begin
			bimode = {1'b0, i_single_weighting_bit};
			single = i_single_weighting_bit;
		end
		dw0_next = 32'h00000000;
		dw0_next[26:25] = {2{adaptive & field_mb}};
		dw0_next[24]    = parity;
		dw0_next[22:20] = mv_code;
		dw0_next[19]    = i_mb_cfg[`AMIP_MB_DCY];
		dw0_next[18]    = i_mb_cfg[`AMIP_MB_DCB];
		dw0_next[17]    = i_mb_cfg[`AMIP_MB_DCR];
		dw0_next[15]    = i_mb_cfg[`AMIP_MB_XFORM];
		dw0_next[14]    = field_mb;
		dw0_next[13]    = intra;
		dw0_next[12:8]  = i_mb_cfg[`AMIP_MB_KIND];
		dw0_next[7:6]   = bimode;
		dw0_next[5]     = single;
		dw0_next[3:2]   = i_chroma_sampling_code;
		dw0_next[1]     = adaptive;
		dw0_next[0]     = i_picture_is_field_bit;
		dw1_next = {16'h0000, i_mb_row_position, i_mb_column_position};
		dw2_next = {18'h0000, i_mb_cfg[`AMIP_MB_CBP], i_mb_cfg[`AMIP_MB_CBPR], i_mb_cfg[`AMIP_MB_CBPB]};
	end

	always @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			o_dw0 <= 32'h00000000;
			o_dw1 <= 32'h00000000;
			o_dw2 <= 32'h00000000;
		end else if (i_capture) begin
			o_dw0 <= dw0_next;
			o_dw1 <= dw1_next;
			o_dw2 <= dw2_next;
		end
	end

endmodule

// ---- verilog/amip_send.v ----
// sends the three latched dwords in order with valid and ready
`timescale 1ns/1ps
`include "amip_consts.vh"
module amip_send (
	input  wire        i_core_clk,
	input  wire        i_rst_n,
	input  wire        i_start,
	input  wire [31:0] i_dw0,
	input  wire [31:0] i_dw1,
	input  wire [31:0] i_dw2,
	input  wire        i_ready,
	output reg         o_valid,
	output reg  [31:0] o_dword,
	output reg  [1:0]  o_index,
	output reg         o_last,
	output reg         o_done
);

	always @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			o_valid <= 1'b0;
			o_dword <= 32'h00000000;
			o_index <= 2'h0;
			o_last  <= 1'b0;
			o_done  <= 1'b0;
		end else begin
			o_done <= 1'b0;
			if (i_start && !o_valid) begin
				o_valid <= 1'b1;
				o_dword <= i_dw0;
				o_index <= 2'h0;
				o_last  <= 1'b0;
			end else if (o_valid && i_ready) begin
				if (o_index == `AMIP_LAST_INDEX) begin
					o_valid <= 1'b0;
					o_dword <= 32'h00000000;
					o_index <= 2'h0;
					o_last  <= 1'b0;
					o_done  <= 1'b1;
				end else begin
					o_index <= o_index + 2'h1;
					o_dword <= (o_index == 2'h0) ? i_dw1 : i_dw2;
					o_last  <= (o_index == 2'h1);
				end
			end
		end
	end

endmodule

// ---- verilog/amip_host_top.v ----
// host controller that builds and sends macroblock inline command dwords
//
// Our own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "amip_consts.vh"
module amip_host_top (
	input  wire        i_core_clk,
	input  wire        i_rst_n,
	input  wire [7:0]  i_addr,
	input  wire [31:0] i_wdata,
	input  wire        i_wr,
	input  wire        i_rd,
	output reg  [31:0] o_rdata,
	input  wire        i_cmd_ready,
	output wire        o_cmd_valid,
	output wire [31:0] o_cmd_dword,
	output wire [1:0]  o_cmd_index,
	output wire        o_cmd_last,
	output reg         o_busy
);

	reg  [7:0]  pic_stage_reg;
	reg  [7:0]  pic_active_reg;
	reg         pic_open_reg;
	reg  [15:0] mb_pos_reg;
	reg  [29:0] mb_cfg_reg;
	reg         start_reg;
	reg  [3:0]  err_reg;
	reg  [3:0]  err_next;
	reg  [7:0]  sent_cnt_reg;
	reg  [31:0] rdata_next;
	wire [31:0] dw0;
	wire [31:0] dw1;
	wire [31:0] dw2;
	wire        done;
	wire        wr_ctrl;
	wire        go_req;
	wire        pic_req;
	wire        clr_req;
	wire        mb_intra;
	wire        mb_bidir;
	wire [2:0]  mb_mv;
	wire        mv_legal;
	wire        bimode_legal;
	wire        chroma_legal;
	wire        go_ok;
	wire        pic_ok;

	// control strobes decoded from a write to the control register
	assign wr_ctrl = i_wr && (i_addr == `AMIP_ADDR_CTRL);
	assign go_req  = wr_ctrl && i_wdata[`AMIP_CTRL_GO];
	assign pic_req = wr_ctrl && i_wdata[`AMIP_CTRL_PIC];
	assign clr_req = wr_ctrl && i_wdata[`AMIP_CTRL_CLR];

	assign mb_intra = mb_cfg_reg[`AMIP_MB_INTRA];
	assign mb_bidir = mb_cfg_reg[`AMIP_MB_BIDIR];
	assign mb_mv    = mb_cfg_reg[`AMIP_MB_MV];

	assign mv_legal = (mb_mv == `AMIP_MV_NONE) || (mb_mv == `AMIP_MV_ONE_PAIR) ||
	                  (mb_mv == `AMIP_MV_FOUR_PAIR) || (mb_mv == `AMIP_MV_SIXTEEN) ||
	                  (mb_mv == `AMIP_MV_SIXTEEN_PR) || mb_intra;

	assign bimode_legal = mb_intra || !mb_bidir ||
	                      (pic_active_reg[`AMIP_PIC_BIMODE] != `AMIP_BIMODE_RSVD);

	assign chroma_legal = (pic_stage_reg[`AMIP_PIC_CHROMA] == `AMIP_CHROMA_MONO) ||
	                      (pic_stage_reg[`AMIP_PIC_CHROMA] == `AMIP_CHROMA_420);

	// a macroblock may go only when idle, inside an opened picture, with legal codes
	assign go_ok  = !o_busy && !start_reg && pic_open_reg && mv_legal && bimode_legal;
	assign pic_ok = !o_busy && !start_reg && chroma_legal;

	// picture staging and the active picture copy
	always @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			pic_stage_reg  <= `AMIP_PIC_RST;
			pic_active_reg <= `AMIP_PIC_RST;
			pic_open_reg   <= 1'b0;
		end else begin
			if (i_wr && (i_addr == `AMIP_ADDR_PIC))
				pic_stage_reg <= i_wdata[7:0];
			if (pic_req && pic_ok) begin
				pic_active_reg <= pic_stage_reg;
				pic_open_reg   <= 1'b1;
			end
		end
	end

	// per macroblock position and configuration, free to change while sending
	always @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			mb_pos_reg <= `AMIP_POS_RST;
			mb_cfg_reg <= `AMIP_MB_RST;
		end else begin
			if (i_wr && (i_addr == `AMIP_ADDR_POS))
				mb_pos_reg <= i_wdata[15:0];
			if (i_wr && (i_addr == `AMIP_ADDR_MB))
				mb_cfg_reg <= i_wdata[29:0];
		end
	end

	// sticky refusal flags; a new refusal wins over a clear in the same cycle
	always @* begin
		err_next = err_reg;
		if (clr_req)
			err_next = `AMIP_ERR_RST;
		if (go_req && (o_busy || start_reg))
			err_next[0] = 1'b1;
		if (pic_req && (o_busy || start_reg))
			err_next[0] = 1'b1;
		if (pic_req && !chroma_legal)
			err_next[1] = 1'b1;
		if (go_req && !mv_legal)
			err_next[2] = 1'b1;
		if (go_req && !bimode_legal)
			err_next[3] = 1'b1;
		if (go_req && !pic_open_reg)
			err_next[1] = 1'b1;
	end

	// busy tracking, start pulse and sent counter
	always @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			o_busy       <= 1'b0;
			start_reg    <= 1'b0;
			err_reg      <= `AMIP_ERR_RST;
			sent_cnt_reg <= `AMIP_CNT_RST;
		end else begin
			err_reg   <= err_next;
			start_reg <= go_req && go_ok;
			if (go_req && go_ok)
				o_busy <= 1'b1;
			else if (done)
				o_busy <= 1'b0;
			if (done)
				sent_cnt_reg <= sent_cnt_reg + 8'h01;
		end
	end

	// register read mux; unmapped addresses read zero
	always @* begin
		rdata_next = 32'h00000000;
		case (i_addr)
			`AMIP_ADDR_PIC: begin
				rdata_next = {24'h000000, pic_stage_reg};
			end
			`AMIP_ADDR_POS: begin
				rdata_next = {16'h0000, mb_pos_reg};
			end
			`AMIP_ADDR_MB: begin
				rdata_next = {2'h0, mb_cfg_reg};
			end
			`AMIP_ADDR_STAT: begin
				rdata_next = {16'h0000, sent_cnt_reg, 1'b0, pic_open_reg, err_reg, start_reg, o_busy};
			end
			`AMIP_ADDR_ACTIVE: begin
				rdata_next = {24'h000000, pic_active_reg};
			end
			`AMIP_ADDR_DW0: begin
				rdata_next = dw0;
			end
			`AMIP_ADDR_DW1: begin
				rdata_next = dw1;
			end
			`AMIP_ADDR_DW2: begin
				rdata_next = dw2;
			end
			default: begin
				rdata_next = 32'h00000000;
			end
		endcase
	end

	// read data stand only in the cycle after the read strobe
	always @(posedge i_core_clk) begin
		if (!i_rst_n)
			o_rdata <= 32'h00000000;
		else if (i_rd)
			o_rdata <= rdata_next;
		else
			o_rdata <= 32'h00000000;
	end

	amip_pack u_pack (
		.i_core_clk                   (i_core_clk),
		.i_rst_n                      (i_rst_n),
		.i_capture                    (go_req && go_ok),
		.i_chroma_sampling_code       (pic_active_reg[`AMIP_PIC_CHROMA]),
		.i_picture_is_field_bit       (pic_active_reg[`AMIP_PIC_FIELD]),
		.i_adaptive_frame_picture_bit (pic_active_reg[`AMIP_PIC_ADAPT]),
		.i_bottom_field_bit           (pic_active_reg[`AMIP_PIC_BOTTOM]),
		.i_bidir_weighting_mode       (pic_active_reg[`AMIP_PIC_BIMODE]),
		.i_single_weighting_bit       (pic_active_reg[`AMIP_PIC_SINGLE]),
		.i_mb_column_position         (mb_pos_reg[7:0]),
		.i_mb_row_position            (mb_pos_reg[15:8]),
		.i_mb_cfg                     (mb_cfg_reg),
		.o_dw0                        (dw0),
		.o_dw1                        (dw1),
		.o_dw2                        (dw2)
	);

	// dword sender toward the device command input
	amip_send u_send (
		.i_core_clk (i_core_clk),
		.i_rst_n    (i_rst_n),
		.i_start    (start_reg),
		.i_dw0      (dw0),
		.i_dw1      (dw1),
		.i_dw2      (dw2),
		.i_ready    (i_cmd_ready),
		.o_valid    (o_cmd_valid),
		.o_dword    (o_cmd_dword),
		.o_index    (o_cmd_index),
		.o_last     (o_cmd_last),
		.o_done     (done)
	);

endmodule

// ---- sim/amip_props.sv ----
// assertions on the ports of the macroblock command host
`timescale 1ns/1ps
module amip_props (
	input wire        i_core_clk,
	input wire        i_rst_n,
	input wire [7:0]  i_addr,
	input wire [31:0] i_wdata,
	input wire        i_wr,
	input wire        i_rd,
	input wire [31:0] o_rdata,
	input wire        i_cmd_ready,
	input wire        o_cmd_valid,
	input wire [31:0] o_cmd_dword,
	input wire [1:0]  o_cmd_index,
	input wire        o_cmd_last,
	input wire        o_busy
);
	// first dword of a macroblock on the link
	wire        first = o_cmd_valid && o_cmd_index == 2'h0;
	wire [31:0] d     = o_cmd_dword;
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);
	rdata_slot_a: assert property (o_rdata != 32'h0 |-> $past(i_rd)) else $error("read data outside slot");
	dword_hold_a: assert property (o_cmd_valid && !i_cmd_ready |=> o_cmd_valid && $stable(o_cmd_dword)
		&& $stable(o_cmd_index)) else $error("dword changed while stalled");
	dword_order_a: assert property (o_cmd_valid && i_cmd_ready && !o_cmd_last |=> o_cmd_valid
		&& o_cmd_index == $past(o_cmd_index) + 2'h1) else $error("dword order broken");
	last_flag_a: assert property (o_cmd_valid |-> o_cmd_last == (o_cmd_index == 2'h2))
		else $error("last flag wrong");
	tail_zero_a: assert property (o_cmd_valid && o_cmd_last |-> d[31:14] == 18'h0)
		else $error("tail dword not zero filled");
	busy_end_a: assert property (o_cmd_valid && i_cmd_ready && o_cmd_last |=> !o_cmd_valid ##1 !o_busy)
		else $error("busy end timing wrong");
	send_start_a: assert property ($rose(o_busy) |=> first) else $error("send did not start");
	chroma_code_a: assert property (first |-> !d[3]) else $error("reserved chroma sent");
	adapt_zero_a: assert property (first && d[0] |-> !d[1]) else $error("adaptive set in field");
	field_ind_a: assert property (first |-> d[26:25] == {2{d[1] & d[14]}}) else $error("field ind wrong");
	parity_zero_a: assert property (first && !d[0] && !d[1] |-> !d[24]) else $error("parity set");
	mv_legal_a: assert property (first |-> !(d[22:20] inside {3'h1, 3'h3, 3'h7})) else $error("mv bad");
	intra_zero_a: assert property (first && d[13] |-> d[22:20] == 3'h0 && d[7:5] == 3'h0)
		else $error("intra fields not zero");
	rsvd_zero_a: assert property (first |-> d[31:27] == 5'h0 && !d[23] && !d[16] && !d[4])
		else $error("reserved bits set");
endmodule

bind amip_host_top amip_props i_amip_props (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
	.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_cmd_ready(i_cmd_ready),
	.o_cmd_valid(o_cmd_valid), .o_cmd_dword(o_cmd_dword), .o_cmd_index(o_cmd_index),
	.o_cmd_last(o_cmd_last), .o_busy(o_busy));

// ---- sim/amip_cmd_sink.sv ----
// far-side model that takes the inline dwords, promptly or with stalls
`timescale 1ns/1ps
module amip_cmd_sink (
	input  wire i_core_clk,
	input  wire i_rst_n,
	input  wire i_slow,
	output reg  o_cmd_ready
);
	reg [7:0] lfsr_reg;
	always @(posedge i_core_clk) begin
		lfsr_reg <= {lfsr_reg[6:0], lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3]};
		o_cmd_ready <= !i_slow | lfsr_reg[0];
		if (!i_rst_n) begin
			lfsr_reg <= 8'hA5;
			o_cmd_ready <= 1'b0;
		end
	end
endmodule

// ---- sim/amip_host_top_test.sv ----
// self-checking bench for the macroblock command host
`timescale 1ns/1ps
`include "amip_consts.vh"
module amip_host_top_test;
	reg         clk, rst_n, wr_s, rd_s, slow, rd_d;
	reg  [7:0]  addr, cnt;
	reg  [31:0] wdata, seed, pic, mb, pos;
	wire [31:0] rdata, dword;
	wire [1:0]  idx;
	wire        valid, last, busy, ready;
	reg  [34:0] exp_q[$];
	reg  [31:0] rd_q[$];
	integer     mismatches, tests_run, i, n;

	amip_host_top i_amip_host_top (.i_core_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata),
		.i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata), .i_cmd_ready(ready), .o_cmd_valid(valid),
		.o_cmd_dword(dword), .o_cmd_index(idx), .o_cmd_last(last), .o_busy(busy));
	amip_cmd_sink i_amip_cmd_sink (.i_core_clk(clk), .i_rst_n(rst_n), .i_slow(slow), .o_cmd_ready(ready));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	function [31:0] xs(input [31:0] x);
		reg [31:0] y;
		begin
			y = x ^ (x << 13);
			y = y ^ (y >> 17);
			xs = y ^ (y << 5);
		end
	endfunction

	// expected first dword from picture and macroblock settings
	function [31:0] ex0(input [7:0] p, input [29:0] m);
		reg a, f, par;
		reg [2:0] w;
		begin
			f = p[2];
			a = p[3] & ~f;
			par = a ? (m[10] & m[18]) : (f & p[4]);
			w = m[11] ? 3'h0 : (m[17] ? {p[6:5], p[7]} : {1'b0, p[7], p[7]});
			ex0 = {5'h0, {2{a & m[10]}}, par, 1'b0, m[11] ? 3'h0 : m[8:6], m[19], m[20], m[21], 1'b0,
				m[9], m[10], m[11], m[16:12], w, 1'b0, p[1:0], a, f};
		end
	endfunction

	task chk(input [34:0] g, input [34:0] e);
		begin
			tests_run = tests_run + 1;
			if (g !== e) begin
				mismatches = mismatches + 1;
				$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
			end
		end
	endtask

	task put_w(input [7:0] a, input [31:0] d);
		begin
			@(posedge clk);
			wr_s <= 1'b1;
			addr <= a;
			wdata <= d;
			@(posedge clk);
			wr_s <= 1'b0;
		end
	endtask

	task get_r(input [7:0] a, input [31:0] e);
		begin
			rd_q.push_back(e);
			@(posedge clk);
			rd_s <= 1'b1;
			addr <= a;
			@(posedge clk);
			rd_s <= 1'b0;
		end
	endtask

	task report_and_stop;
		begin
			$display("checks %0d mismatches %0d", tests_run, mismatches);
			if (mismatches == 0 && tests_run > 0)
				$display("TB: PASS");
			else
				$display("TB: FAIL");
			$finish;
		end
	endtask

	// compare accepted dwords and read answers with the oldest note
	always @(posedge clk) begin
		if (rst_n && valid && ready) begin
			if (exp_q.size() == 0)
				chk({last, idx, dword}, ~{last, idx, dword});
			else
				chk({last, idx, dword}, exp_q.pop_front());
		end
		if (rd_d)
			chk({3'h0, rdata}, {3'h0, rd_q.pop_front()});
		rd_d <= rd_s;
	end

	initial begin
		repeat (20000) @(posedge clk);
		mismatches = mismatches + 1;
		report_and_stop;
	end

	initial begin
		{rst_n, wr_s, rd_s, slow, rd_d, addr, wdata, cnt} = 0;
		seed = 32'hc397;
		mismatches = 0;
		tests_run = 0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		// reset state, unmapped read, go and reserved chroma refused
		get_r(`AMIP_ADDR_STAT, 32'h0);
		get_r(8'hFC, 32'h0);
		put_w(`AMIP_ADDR_CTRL, 32'h1);
		get_r(`AMIP_ADDR_STAT, 32'h8);
		for (i = 2; i < 4; i = i + 1) begin
			put_w(`AMIP_ADDR_CTRL, 32'h4);
			put_w(`AMIP_ADDR_PIC, i);
			put_w(`AMIP_ADDR_CTRL, 32'h2);
			get_r(`AMIP_ADDR_STAT, 32'h8);
		end
		$display("refusal test done");
		// random macroblocks, each met mid-send by a rewrite and a second go; the sink stalls on odd rounds
		for (i = 0; i < 15; i = i + 1) begin
			slow <= i[0];
			seed = xs(seed);
			pic = {24'h0, seed[7:2], 1'b0, seed[0]};
			if (&pic[6:5])
				pic[6] = 1'b0;
			pos = seed[31:16];
			seed = xs(seed);
			mb = {2'h0, seed[29:0]};
			if (!mb[11])
				mb[8:6] = (i % 5 < 3) ? 2 * (i % 5) : i % 5 + 2;
			put_w(`AMIP_ADDR_CTRL, 32'h4);
			put_w(`AMIP_ADDR_PIC, pic);
			put_w(`AMIP_ADDR_CTRL, 32'h2);
			put_w(`AMIP_ADDR_POS, pos);
			put_w(`AMIP_ADDR_MB, mb);
			exp_q.push_back({3'h0, ex0(pic[7:0], mb[29:0])});
			exp_q.push_back({3'h1, 16'h0, pos[15:0]});
			exp_q.push_back({3'h6, 18'h0, mb[5:0], mb[29:26], mb[25:22]});
			put_w(`AMIP_ADDR_CTRL, 32'h1);
			// rewrite as intra so the refused go raises only the busy refusal
			put_w(`AMIP_ADDR_MB, ~mb | 32'h800);
			put_w(`AMIP_ADDR_CTRL, 32'h1);
			n = 0;
			while (busy !== 1'b0 && n < 400) begin
				@(posedge clk);
				n = n + 1;
			end
			chk({34'h0, n >= 400}, 35'h0);
			cnt = cnt + 8'h01;
			get_r(`AMIP_ADDR_STAT, {16'h0, cnt, 8'h44});
			get_r(`AMIP_ADDR_DW0, ex0(pic[7:0], mb[29:0]));
		end
		$display("macroblock test done");
		// reserved motion vector codes and bidir mode 11 are refused
		for (i = 0; i < 3; i = i + 1) begin
			put_w(`AMIP_ADDR_CTRL, 32'h4);
			put_w(`AMIP_ADDR_MB, (i == 2 ? 7 : 2 * i + 1) << 6);
			put_w(`AMIP_ADDR_CTRL, 32'h1);
			get_r(`AMIP_ADDR_STAT, {16'h0, cnt, 8'h50});
		end
		put_w(`AMIP_ADDR_CTRL, 32'h4);
		put_w(`AMIP_ADDR_PIC, 32'h60);
		put_w(`AMIP_ADDR_CTRL, 32'h2);
		put_w(`AMIP_ADDR_MB, 32'h20000);
		put_w(`AMIP_ADDR_CTRL, 32'h1);
		get_r(`AMIP_ADDR_STAT, {16'h0, cnt, 8'h60});
		repeat (3) @(posedge clk);
		chk(exp_q.size(), 35'h0);
		$display("reserved code test done");
		report_and_stop;
	end
endmodule
